// File: src/ocs_event_flags.sv
`timescale 1ns/1ps
`default_nettype none
module ocs_event_flags
   import ocs_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic [OCS_EVT_W-1:0] set_i,
   input wire logic [OCS_EVT_W-1:0] clr_i,
   output logic [OCS_EVT_W-1:0] flags_o
);

   // ==========================================================
   // Sticky flags
   logic [OCS_EVT_W-1:0] flags_r;
   logic [OCS_EVT_W-1:0] flags_nxt;

   // A new event in the clear cycle survives
   assign flags_nxt = (flags_r & ~clr_i) | set_i;

   always_ff @(posedge sys_clk_i)
   begin
      if (!rstn_i)
         flags_r <= '0;
      else
         flags_r <= flags_nxt;
   end

   assign flags_o = flags_r;

endmodule : ocs_event_flags
`default_nettype wire

// File: src/ocs_pkg.sv
package ocs_pkg;

   // ==========================================================
   // Register offsets
   localparam logic [7:0] OCS_OFS_FLUSH = 8'h55;
   localparam logic [7:0] OCS_OFS_OUT0 = 8'h56;
   localparam logic [7:0] OCS_OFS_OUT1 = 8'h57;
   localparam logic [7:0] OCS_OFS_OUT2 = 8'h58;
   localparam logic [7:0] OCS_OFS_FP8K = 8'h59;
   localparam logic [7:0] OCS_OFS_FP2K = 8'h5a;
   localparam logic [7:0] OCS_OFS_OUT5 = 8'h5b;
   localparam logic [7:0] OCS_OFS_OUT6 = 8'h5c;
   localparam logic [7:0] OCS_OFS_OUT7 = 8'h5d;
   localparam logic [7:0] OCS_OFS_EVT_LO = 8'h5e;
   localparam logic [7:0] OCS_OFS_EVT_HI = 8'h5f;
   localparam logic [7:0] OCS_OFS_EN_LO = 8'h60;
   localparam logic [7:0] OCS_OFS_EN_HI = 8'h61;

   // ==========================================================
   // Field positions and widths
   localparam int OCS_FLUSH_SCOPE_BIT = 0;
   localparam int OCS_EVT_W = 10;
   localparam int OCS_EVT_LO_W = 8;
   localparam int OCS_EVT_HI_W = 2;
   localparam int OCS_REF_N = 12;
   localparam int OCS_EVT_REF_LOST = 8;
   localparam int OCS_EVT_REF_GAINED = 9;

   // ==========================================================
   // Reset values
   localparam logic [1:0] OCS_RST_OUT0 = 2'h0;
   localparam logic [2:0] OCS_RST_OUT1 = 3'h1;
   localparam logic [2:0] OCS_RST_OUT2 = 3'h2;
   localparam logic [5:0] OCS_RST_FP8K = 6'h3f;
   localparam logic [5:0] OCS_RST_FP2K = 6'h3f;
   localparam logic [1:0] OCS_RST_OUT5 = 2'h2;
   localparam logic [3:0] OCS_RST_OUT6 = 4'h1;
   localparam logic [1:0] OCS_RST_OUT7 = 2'h2;
   localparam logic [9:0] OCS_RST_EN = 10'h000;

   // ==========================================================
   // Special codes
   localparam logic [1:0] OCS_CODE2_RSVD = 2'h3;
   localparam logic [5:0] OCS_PULSE_HALF = 6'h3f;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic [1:0] out0;
      logic [2:0] out1;
      logic [2:0] out2;
      logic [5:0] fp8k;
      logic [5:0] fp2k;
      logic [1:0] out5;
      logic [3:0] out6;
      logic [1:0] out7;
   } ocs_sel_type;

   typedef struct packed {
      logic [7:0] enable;
      logic fp8k_half;
      logic fp2k_half;
   } ocs_live_type;

   typedef struct packed {
      logic pulse;
      logic both;
   } ocs_flush_type;

endpackage : ocs_pkg

// File: src/ocs_regs.sv
`timescale 1ns/1ps
`default_nettype none
module ocs_regs
   import ocs_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_rvalid_o,
   input wire logic [3:0] primary_event_i,
   input wire logic [3:0] secondary_event_i,
   input wire logic [OCS_REF_N-1:0] ref_qualified_i,
   output ocs_flush_type hist_flush_o,
   output ocs_sel_type sel_o,
   output ocs_live_type live_o,
   output logic [OCS_EVT_W-1:0] event_flags_o,
   output logic event_irq_o
);

   // ==========================================================
   // Address decode
   function automatic logic wr_hit(input logic wr, input logic [7:0] addr, input logic [7:0] ofs);
      wr_hit = wr && (addr == ofs);
   endfunction : wr_hit

   wire logic wr_flush;
   wire logic wr_out0;
   wire logic wr_out1;
   wire logic wr_out2;
   wire logic wr_fp8k;
   wire logic wr_fp2k;
   wire logic wr_out5;
   wire logic wr_out6;
   wire logic wr_out7;
   wire logic wr_evt_lo;
   wire logic wr_evt_hi;
   wire logic wr_en_lo;
   wire logic wr_en_hi;

   assign wr_flush = wr_hit(reg_wr_i, reg_addr_i, OCS_OFS_FLUSH);
   assign wr_out0 = wr_hit(reg_wr_i, reg_addr_i, OCS_OFS_OUT0);
   assign wr_out1 = wr_hit(reg_wr_i, reg_addr_i, OCS_OFS_OUT1);
   assign wr_out2 = wr_hit(reg_wr_i, reg_addr_i, OCS_OFS_OUT2);
   assign wr_fp8k = wr_hit(reg_wr_i, reg_addr_i, OCS_OFS_FP8K);
   assign wr_fp2k = wr_hit(reg_wr_i, reg_addr_i, OCS_OFS_FP2K);
   assign wr_out5 = wr_hit(reg_wr_i, reg_addr_i, OCS_OFS_OUT5);
   assign wr_out6 = wr_hit(reg_wr_i, reg_addr_i, OCS_OFS_OUT6);
   assign wr_out7 = wr_hit(reg_wr_i, reg_addr_i, OCS_OFS_OUT7);
   assign wr_evt_lo = wr_hit(reg_wr_i, reg_addr_i, OCS_OFS_EVT_LO);
   assign wr_evt_hi = wr_hit(reg_wr_i, reg_addr_i, OCS_OFS_EVT_HI);
   assign wr_en_lo = wr_hit(reg_wr_i, reg_addr_i, OCS_OFS_EN_LO);
   assign wr_en_hi = wr_hit(reg_wr_i, reg_addr_i, OCS_OFS_EN_HI);

   // ==========================================================
   // Flush command
   ocs_flush_type flush_r;
   ocs_flush_type flush_nxt;

   // Scope is held so the history logic may sample it with the pulse
   assign flush_nxt.pulse = wr_flush;
   assign flush_nxt.both = wr_flush ? reg_wdata_i[OCS_FLUSH_SCOPE_BIT] : flush_r.both;

   always_ff @(posedge sys_clk_i)
   begin
      if (!rstn_i)
         flush_r <= '0;
      else
         flush_r <= flush_nxt;
   end

   // ==========================================================
   // Output selectors, only the defined width is stored
   ocs_sel_type sel_r;
   ocs_sel_type sel_nxt;

   assign sel_nxt.out0 = wr_out0 ? reg_wdata_i[1:0] : sel_r.out0;
   assign sel_nxt.out1 = wr_out1 ? reg_wdata_i[2:0] : sel_r.out1;
   assign sel_nxt.out2 = wr_out2 ? reg_wdata_i[2:0] : sel_r.out2;
   assign sel_nxt.fp8k = wr_fp8k ? reg_wdata_i[5:0] : sel_r.fp8k;
   assign sel_nxt.fp2k = wr_fp2k ? reg_wdata_i[5:0] : sel_r.fp2k;
   assign sel_nxt.out5 = wr_out5 ? reg_wdata_i[1:0] : sel_r.out5;
   assign sel_nxt.out6 = wr_out6 ? reg_wdata_i[3:0] : sel_r.out6;
   assign sel_nxt.out7 = wr_out7 ? reg_wdata_i[1:0] : sel_r.out7;

   always_ff @(posedge sys_clk_i)
   begin
      if (!rstn_i)
      begin
         sel_r.out0 <= OCS_RST_OUT0;
         sel_r.out1 <= OCS_RST_OUT1;
         sel_r.out2 <= OCS_RST_OUT2;
         sel_r.fp8k <= OCS_RST_FP8K;
         sel_r.fp2k <= OCS_RST_FP2K;
         sel_r.out5 <= OCS_RST_OUT5;
         sel_r.out6 <= OCS_RST_OUT6;
         sel_r.out7 <= OCS_RST_OUT7;
      end
      else
         sel_r <= sel_nxt;
   end

   // ==========================================================
   // Live output enables, decoded from the next selector value
   // so that the registered enables line up with sel_r
   ocs_live_type live_nxt;
   ocs_live_type live_r;

   ocs_sel_decode u_decode
   (
      .sel_i(sel_nxt),
      .live_o(live_nxt)
   );

   always_ff @(posedge sys_clk_i)
   begin
      if (!rstn_i)
      begin
         // Only output 0 starts switched off
         live_r.enable <= 8'hfe;
         live_r.fp8k_half <= 1'b1;
         live_r.fp2k_half <= 1'b1;
      end
      else
         live_r <= live_nxt;
   end

   // ==========================================================
   // Reference qualification edges
   // The first sample after reset only primes the history, so a
   // reference already qualified at start-up raises no event
   logic [OCS_REF_N-1:0] ref_prev_r;
   logic ref_primed_r;
   wire logic ref_lost;
   wire logic ref_gained;

   assign ref_lost = ref_primed_r && |(ref_prev_r & ~ref_qualified_i);
   assign ref_gained = ref_primed_r && |(~ref_prev_r & ref_qualified_i);

   always_ff @(posedge sys_clk_i)
   begin
      if (!rstn_i)
      begin
         ref_prev_r <= '0;
         ref_primed_r <= 1'b0;
      end
      else
      begin
         ref_prev_r <= ref_qualified_i;
         ref_primed_r <= 1'b1;
      end
   end

   // ==========================================================
   // Event flags
   wire logic [OCS_EVT_W-1:0] evt_set;
   wire logic [OCS_EVT_W-1:0] evt_clr;
   wire logic [OCS_EVT_W-1:0] evt_flags;

   // Clears come only from writes to the two event offsets
   assign evt_set = {ref_gained, ref_lost, secondary_event_i, primary_event_i};
   assign evt_clr = {(wr_evt_hi ? reg_wdata_i[OCS_EVT_HI_W-1:0] : 2'h0),
                     (wr_evt_lo ? reg_wdata_i : 8'h00)};

   ocs_event_flags u_flags
   (
      .sys_clk_i(sys_clk_i),
      .rstn_i(rstn_i),
      .set_i(evt_set),
      .clr_i(evt_clr),
      .flags_o(evt_flags)
   );

   // ==========================================================
   // Event enables and request
   logic [OCS_EVT_W-1:0] en_r;
   logic [OCS_EVT_W-1:0] en_nxt;
   logic irq_r;
   logic [OCS_EVT_W-1:0] evt_flags_r;

   // Registered request costs a cycle but keeps the output glitch free
   assign en_nxt = {(wr_en_hi ? reg_wdata_i[OCS_EVT_HI_W-1:0] : en_r[9:8]),
                    (wr_en_lo ? reg_wdata_i : en_r[7:0])};

   always_ff @(posedge sys_clk_i)
   begin
      if (!rstn_i)
      begin
         en_r <= OCS_RST_EN;
         irq_r <= 1'b0;
         evt_flags_r <= '0;
      end
      else
      begin
         en_r <= en_nxt;
         irq_r <= |(evt_flags & en_r);
         evt_flags_r <= evt_flags;
      end
   end

   // ==========================================================
   // Read data, one cycle after the strobe
   // Reads have no side effects; the flush register and
   // unmapped offsets read zero
   logic [7:0] rd_mux;
   logic [7:0] rdata_r;
   logic rvalid_r;
   wire logic [7:0] rb_flush;
   wire logic [7:0] rb_out0;
   wire logic [7:0] rb_out1;
   wire logic [7:0] rb_out2;
   wire logic [7:0] rb_fp8k;
   wire logic [7:0] rb_fp2k;
   wire logic [7:0] rb_out5;
   wire logic [7:0] rb_out6;
   wire logic [7:0] rb_out7;
   wire logic [7:0] rb_evt_lo;
   wire logic [7:0] rb_evt_hi;
   wire logic [7:0] rb_en_lo;
   wire logic [7:0] rb_en_hi;

   // Unused selector bits are not stored, so they pad with zero here;
   // the flush command keeps no state worth showing
   assign rb_flush = 8'h00;
   assign rb_out0 = {6'h00, sel_r.out0};
   assign rb_out1 = {5'h00, sel_r.out1};
   assign rb_out2 = {5'h00, sel_r.out2};
   assign rb_fp8k = {2'h0, sel_r.fp8k};
   assign rb_fp2k = {2'h0, sel_r.fp2k};
   assign rb_out5 = {6'h00, sel_r.out5};
   assign rb_out6 = {4'h0, sel_r.out6};
   assign rb_out7 = {6'h00, sel_r.out7};
   assign rb_evt_lo = evt_flags[7:0];
   assign rb_evt_hi = {6'h00, evt_flags[9:8]};
   assign rb_en_lo = en_r[7:0];
   assign rb_en_hi = {6'h00, en_r[9:8]};

   always_comb
   begin
      rd_mux = 8'h00;
      case (reg_addr_i)
         OCS_OFS_FLUSH: rd_mux = rb_flush;
         OCS_OFS_OUT0: rd_mux = rb_out0;
         OCS_OFS_OUT1: rd_mux = rb_out1;
         OCS_OFS_OUT2: rd_mux = rb_out2;
         OCS_OFS_FP8K: rd_mux = rb_fp8k;
         OCS_OFS_FP2K: rd_mux = rb_fp2k;
         OCS_OFS_OUT5: rd_mux = rb_out5;
         OCS_OFS_OUT6: rd_mux = rb_out6;
         OCS_OFS_OUT7: rd_mux = rb_out7;
         OCS_OFS_EVT_LO: rd_mux = rb_evt_lo;
         OCS_OFS_EVT_HI: rd_mux = rb_evt_hi;
         OCS_OFS_EN_LO: rd_mux = rb_en_lo;
         OCS_OFS_EN_HI: rd_mux = rb_en_hi;
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!rstn_i)
      begin
         rdata_r <= 8'h00;
         rvalid_r <= 1'b0;
      end
      else
      begin
         rdata_r <= reg_rd_i ? rd_mux : 8'h00;
         rvalid_r <= reg_rd_i;
      end
   end

   // ==========================================================
   // Outputs
   assign reg_rdata_o = rdata_r;
   assign reg_rvalid_o = rvalid_r;
   assign hist_flush_o = flush_r;
   assign sel_o = sel_r;
   assign live_o = live_r;
   assign event_flags_o = evt_flags_r;
   assign event_irq_o = irq_r;

endmodule : ocs_regs
`default_nettype wire

// File: src/ocs_sel_decode.sv
`timescale 1ns/1ps
`default_nettype none
module ocs_sel_decode
   import ocs_pkg::*;
(
   input wire ocs_sel_type sel_i,
   output ocs_live_type live_o
);

   // ==========================================================
   // Two-bit selectors share one reserved code
   function automatic logic two_bit_live(input logic [1:0] code);
      two_bit_live = (code != 2'h0) && (code != OCS_CODE2_RSVD);
   endfunction : two_bit_live

   wire logic out6_rsvd;
   assign out6_rsvd = (sel_i.out6 inside {4'h6, 4'h7, 4'h8, 4'he, 4'hf});

   // ==========================================================
   // Reserved codes stay stored but switch the output off
   assign live_o.enable[0] = two_bit_live(sel_i.out0);
   assign live_o.enable[1] = (sel_i.out1 != 3'h0);
   assign live_o.enable[2] = (sel_i.out2 != 3'h0);
   assign live_o.enable[3] = (sel_i.fp8k != 6'h00);
   assign live_o.enable[4] = (sel_i.fp2k != 6'h00);
   assign live_o.enable[5] = two_bit_live(sel_i.out5);
   assign live_o.enable[6] = (sel_i.out6 != 4'h0) && !out6_rsvd;
   assign live_o.enable[7] = two_bit_live(sel_i.out7);
   assign live_o.fp8k_half = (sel_i.fp8k == OCS_PULSE_HALF);
   assign live_o.fp2k_half = (sel_i.fp2k == OCS_PULSE_HALF);

endmodule : ocs_sel_decode
`default_nettype wire

// File: verif/ocs_regs_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module ocs_regs_assertions
   import ocs_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic reg_rvalid_o,
   input wire logic [3:0] primary_event_i,
   input wire logic [OCS_REF_N-1:0] ref_qualified_i,
   input wire ocs_flush_type hist_flush_o,
   input wire ocs_sel_type sel_o,
   input wire ocs_live_type live_o,
   input wire logic [OCS_EVT_W-1:0] event_flags_o
);
   // ====================
   // Decodes
   wire logic flush_wr = reg_wr_i && (reg_addr_i == OCS_OFS_FLUSH);
   wire logic lo_wr = reg_wr_i && (reg_addr_i == OCS_OFS_EVT_LO);
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rstn_i);
   // ====================
   // Properties
   a_flush_pulse: assert property (
      flush_wr |=> hist_flush_o.pulse && hist_flush_o.both == $past(reg_wdata_i[0]))
      else $error("flush pulse or scope wrong");
   a_flush_idle: assert property (
      !flush_wr |=> !hist_flush_o.pulse) else $error("flush pulse without write");
   a_read_valid: assert property (
      reg_rd_i |=> reg_rvalid_o) else $error("read not answered");
   a_flush_rd_zero: assert property (
      reg_rd_i && reg_addr_i == OCS_OFS_FLUSH |=> reg_rdata_o == 8'h00)
      else $error("flush register read not zero");
   a_out0_store: assert property (
      reg_wr_i && reg_addr_i == OCS_OFS_OUT0 |=> sel_o.out0 == $past(reg_wdata_i[1:0]))
      else $error("output 0 code not stored");
   a_out0_live: assert property (
      live_o.enable[0] == (sel_o.out0 inside {2'h1, 2'h2})) else $error("output 0 enable wrong");
   a_fp8k_half: assert property (
      live_o.fp8k_half == (sel_o.fp8k == OCS_PULSE_HALF)) else $error("half duty wrong");
   a_fp8k_live: assert property (
      live_o.enable[3] == (sel_o.fp8k != 6'h00)) else $error("8 kHz enable wrong");
   a_event_set: assert property (
      primary_event_i[1] |-> ##2 event_flags_o[1]) else $error("event flag not set");
   a_w1c_clear: assert property (
      lo_wr && reg_wdata_i[2] && !primary_event_i[2] |-> ##2 !event_flags_o[2])
      else $error("event flag not cleared");
   a_ref_lost: assert property (
      |($past(ref_qualified_i) & ~ref_qualified_i) |-> ##2 event_flags_o[OCS_EVT_REF_LOST])
      else $error("reference loss not flagged");
endmodule : ocs_regs_assertions

bind ocs_regs ocs_regs_assertions ocs_regs_assertions_inst (
   .sys_clk_i(sys_clk_i),
   .rstn_i(rstn_i),
   .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i),
   .reg_wr_i(reg_wr_i),
   .reg_rd_i(reg_rd_i),
   .reg_rdata_o(reg_rdata_o),
   .reg_rvalid_o(reg_rvalid_o),
   .primary_event_i(primary_event_i),
   .ref_qualified_i(ref_qualified_i),
   .hist_flush_o(hist_flush_o),
   .sel_o(sel_o),
   .live_o(live_o),
   .event_flags_o(event_flags_o)
);
`default_nettype wire

// File: verif/ocs_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module ocs_regs_tb_top
   import ocs_pkg::*;
;
   logic sys_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [7:0] reg_addr_i = 8'h00;
   logic [7:0] reg_wdata_i = 8'h00;
   logic [3:0] prim_ev = 4'h0;
   logic [3:0] sec_ev = 4'h0;
   logic [OCS_REF_N-1:0] ref_q = 12'hfff;
   logic [7:0] reg_rdata_o;
   logic reg_rvalid_o;
   logic event_irq_o;
   ocs_flush_type hist_flush_o;
   ocs_sel_type sel_o;
   ocs_live_type live_o;
   logic [OCS_EVT_W-1:0] event_flags_o;
   int fails = 0;
   int check_count = 0;
   int cycles = 0;
   logic [7:0] rst_val [8] = '{8'h00, 8'h01, 8'h02, 8'h3f, 8'h3f, 8'h02, 8'h01, 8'h02};
   logic [7:0] ones_val [8] = '{8'h03, 8'h07, 8'h07, 8'h3f, 8'h3f, 8'h03, 8'h0f, 8'h03};
   logic [7:0] pw_val [4] = '{8'h00, 8'h01, 8'h3e, 8'h3f};
   logic [3:0] c;

   initial forever #50 sys_clk_i = ~sys_clk_i;

   ocs_regs ocs_regs_inst (
      .sys_clk_i(sys_clk_i),
      .rstn_i(rstn_i),
      .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o),
      .reg_rvalid_o(reg_rvalid_o),
      .primary_event_i(prim_ev),
      .secondary_event_i(sec_ev),
      .ref_qualified_i(ref_q),
      .hist_flush_o(hist_flush_o),
      .sel_o(sel_o),
      .live_o(live_o),
      .event_flags_o(event_flags_o),
      .event_irq_o(event_irq_o)
   );

   // ====================
   // Access tasks
   task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
      check_count++;
      if (g !== e)
      begin
         fails++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic idle(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask : idle

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      #1;
      reg_wr_i = 1'b1;
      reg_addr_i = a;
      reg_wdata_i = d;
      idle(1);
      reg_wr_i = 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge sys_clk_i);
      #1;
      reg_rd_i = 1'b1;
      reg_addr_i = a;
      idle(1);
      reg_rd_i = 1'b0;
      chk("rvalid", 10'h001, {9'h000, reg_rvalid_o});
      chk($sformatf("rdata %h", a), {2'h0, e}, {2'h0, reg_rdata_o});
   endtask : rd

   task automatic pulse(input logic [3:0] p, input logic [3:0] s);
      @(posedge sys_clk_i);
      #1;
      prim_ev = p;
      sec_ev = s;
      idle(1);
      prim_ev = 4'h0;
      sec_ev = 4'h0;
   endtask : pulse

   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : finish_test

   // ====================
   // Hang guard, generous against some 270 cycles of traffic
   always @(posedge sys_clk_i)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         fails++;
         finish_test();
      end
   end

   // ====================
   // Sequence
   initial
   begin
      idle(16);
      rstn_i = 1'b1;
      foreach (rst_val[i]) rd(8'(8'h56 + i), rst_val[i]);
      rd(OCS_OFS_EN_LO, 8'h00);
      rd(OCS_OFS_EVT_LO, 8'h00);
      rd(8'h70, 8'h00);
      chk("live reset", 10'h3fb, live_o);
      foreach (ones_val[i])
      begin
         wr(8'(8'h56 + i), 8'hff);
         rd(8'(8'h56 + i), ones_val[i]);
      end
      chk("reserved enables", 10'h000, {6'h00, live_o.enable[7:5], live_o.enable[0]});
      for (int k = 0; k < 16; k++)
      begin
         c = 4'(k);
         wr(OCS_OFS_OUT0, {4'h0, c});
         wr(OCS_OFS_OUT5, {4'h0, c});
         wr(OCS_OFS_OUT7, {4'h0, c});
         wr(OCS_OFS_OUT6, {4'h0, c});
         chk("enable0", {9'h000, c[1:0] inside {2'h1, 2'h2}}, {9'h000, live_o.enable[0]});
         chk("enable5", {9'h000, c[1:0] inside {2'h1, 2'h2}}, {9'h000, live_o.enable[5]});
         chk("enable7", {9'h000, c[1:0] inside {2'h1, 2'h2}}, {9'h000, live_o.enable[7]});
         chk("enable6", {9'h000, c inside {[4'h1:4'h5], [4'h9:4'hd]}}, {9'h000, live_o.enable[6]});
         chk("sel6", {6'h00, c}, {6'h00, sel_o.out6});
      end
      foreach (pw_val[i])
      begin
         wr(OCS_OFS_FP8K, pw_val[i]);
         wr(OCS_OFS_FP2K, pw_val[i]);
         rd(OCS_OFS_FP2K, pw_val[i]);
         chk("halves", {8'h00, {2{pw_val[i] == 8'h3f}}}, {8'h00, live_o.fp8k_half, live_o.fp2k_half});
         chk("pulse enables", {8'h00, {2{pw_val[i] != 8'h00}}}, {8'h00, live_o.enable[3], live_o.enable[4]});
      end
      wr(OCS_OFS_FLUSH, 8'h00);
      chk("flush lt", 10'h002, {8'h00, hist_flush_o.pulse, hist_flush_o.both});
      wr(OCS_OFS_FLUSH, 8'hff);
      chk("flush both", 10'h003, {8'h00, hist_flush_o.pulse, hist_flush_o.both});
      idle(1);
      chk("flush end", 10'h001, {8'h00, hist_flush_o.pulse, hist_flush_o.both});
      rd(OCS_OFS_FLUSH, 8'h00);
      pulse(4'hf, 4'hf);
      ref_q = 12'h7ff;
      idle(3);
      ref_q = 12'hfff;
      idle(3);
      rd(OCS_OFS_EVT_LO, 8'hff);
      rd(OCS_OFS_EVT_HI, 8'h03);
      chk("flags", 10'h3ff, event_flags_o);
      wr(OCS_OFS_EVT_LO, 8'h0f);
      rd(OCS_OFS_EVT_LO, 8'hf0);
      wr(OCS_OFS_EVT_HI, 8'h01);
      rd(OCS_OFS_EVT_HI, 8'h02);
      wr(OCS_OFS_EVT_LO, 8'hff);
      wr(OCS_OFS_EVT_HI, 8'hff);
      pulse(4'h2, 4'h8);
      rd(OCS_OFS_EVT_LO, 8'h82);
      chk("irq masked", 10'h000, {9'h000, event_irq_o});
      wr(OCS_OFS_EN_LO, 8'h02);
      idle(2);
      chk("irq on", 10'h001, {9'h000, event_irq_o});
      wr(OCS_OFS_EN_LO, 8'h00);
      idle(2);
      chk("irq off", 10'h000, {9'h000, event_irq_o});
      rd(OCS_OFS_EVT_LO, 8'h82);
      finish_test();
   end
endmodule : ocs_regs_tb_top
`default_nettype wire
